// ==== dcl_map.svh ====
// Register offsets, field positions, reset values and limits of the fault log
`ifndef DCL_MAP_SVH
`define DCL_MAP_SVH

// Log geometry and counter widths
`define DCL_NSLOT       5
`define DCL_ICC_W       5
`define DCL_EVT_W       8
`define DCL_ICC_LIMIT   5'd25
`define DCL_ICC_MAX     5'h1f
`define DCL_EVT_MAX     8'hff

// Display encodings: slot shown as prefix digit d plus slot number counted from one
`define DCL_POS_PREFIX  4'hd
`define DCL_DASH        8'hff

// Byte offsets on the register bus
`define DCL_OFS_ENTRY0  8'h00
`define DCL_OFS_CTRL    8'h14
`define DCL_OFS_STS     8'h18
`define DCL_OFS_MASK    8'h1c
`define DCL_OFS_INFO    8'h20

// Entry word fields
`define DCL_F_MAIN      0
`define DCL_F_SUB       8
`define DCL_F_ICC       16
`define DCL_F_ACT       22
`define DCL_F_VLD       23
`define DCL_F_EVT       24

// Control bits (write-one actions, read as zero)
`define DCL_C_CLR_ACT   0
`define DCL_C_CLR_INACT 1

// Status and mask bits
`define DCL_STS_W       3
`define DCL_S_NEW       0
`define DCL_S_AGED      1
`define DCL_S_REFUSED   2
`define DCL_STS_RST     3'h0
`define DCL_MASK_RST    3'h0

`endif

// ==== dcl_pkg.sv ====
// Types shared by the fault log and its register bus slave
`include "dcl_map.svh"

package dcl_pkg;

  // One log entry; codes are two BCD digits each
  typedef struct packed {
    logic                  valid;
    logic                  active;
    logic [7:0]            main_code;
    logic [7:0]            sub_code;
    logic [`DCL_ICC_W-1:0] icc;
    logic [`DCL_EVT_W-1:0] evt;
  } dcl_entry_t;

  // Fault code as reported by a detector
  typedef struct packed {
    logic [7:0] main_code;
    logic [7:0] sub_code;
  } dcl_code_t;

  // What the selector display may see
  typedef struct packed {
    logic [7:0] pos;
    logic [7:0] main_code;
    logic [7:0] sub_code;
    logic       active;
  } dcl_disp_t;

endpackage

// ==== dcl_axil.sv ====
// AXI4-Lite slave front end of the fault log register file
`timescale 1ns/1ps
`default_nettype none

module dcl_axil
  import dcl_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input  wire logic              i_core_clk,
  input  wire logic              i_rst_n,
  input  wire logic              i_awvalid,
  output logic                   o_awready,
  input  wire logic [ADDR_W-1:0] i_awaddr,
  input  wire logic              i_wvalid,
  output logic                   o_wready,
  input  wire logic [31:0]       i_wdata,
  input  wire logic [3:0]        i_wstrb,
  output logic                   o_bvalid,
  input  wire logic              i_bready,
  output logic [1:0]             o_bresp,
  input  wire logic              i_arvalid,
  output logic                   o_arready,
  input  wire logic [ADDR_W-1:0] i_araddr,
  output logic                   o_rvalid,
  input  wire logic              i_rready,
  output logic [31:0]            o_rdata,
  output logic [1:0]             o_rresp,
  output logic                   o_wr_en,
  output logic [ADDR_W-1:0]      o_wr_addr,
  output logic [31:0]            o_wr_data,
  output logic [3:0]             o_wr_strb,
  input  wire logic              i_wr_err,
  output logic [ADDR_W-1:0]      o_rd_addr,
  input  wire logic [31:0]       i_rd_data,
  input  wire logic              i_rd_err
);

  logic              aw_hold_q;
  logic              w_hold_q;
  logic [ADDR_W-1:0] awaddr_q;
  logic [31:0]       wdata_q;
  logic [3:0]        wstrb_q;
  logic              aw_take;
  logic              w_take;
  logic              aw_have;
  logic              w_have;

  // Address and data are taken in either order, held until both are in
  assign o_awready = !aw_hold_q && !o_bvalid;
  assign o_wready  = !w_hold_q && !o_bvalid;
  assign aw_take   = i_awvalid && o_awready;
  assign w_take    = i_wvalid && o_wready;
  assign aw_have   = aw_hold_q || aw_take;
  assign w_have    = w_hold_q || w_take;
  assign o_wr_en   = aw_have && w_have && !o_bvalid;
  assign o_wr_addr = aw_hold_q ? awaddr_q : i_awaddr;
  assign o_wr_data = w_hold_q ? wdata_q : i_wdata;
  assign o_wr_strb = w_hold_q ? wstrb_q : i_wstrb;

  // Write channel holding and response
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      aw_hold_q <= 1'b0;
      w_hold_q  <= 1'b0;
      awaddr_q  <= '0;
      wdata_q   <= 32'h0;
      wstrb_q   <= 4'h0;
      o_bvalid  <= 1'b0;
      o_bresp   <= 2'h0;
    end else begin
      if (aw_take) awaddr_q <= i_awaddr;
      if (w_take) begin
        wdata_q <= i_wdata;
        wstrb_q <= i_wstrb;
      end
      aw_hold_q <= aw_have && !o_wr_en && !o_bvalid;
      w_hold_q  <= w_have && !o_wr_en && !o_bvalid;
      if (o_wr_en) begin
        o_bvalid <= 1'b1;
        o_bresp  <= i_wr_err ? 2'h2 : 2'h0;
      end else if (i_bready) begin
        o_bvalid <= 1'b0;
      end
    end
  end

  // Reads have no side effect, so data is sampled at the address handshake
  assign o_arready = !o_rvalid;
  assign o_rd_addr = i_araddr;

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rvalid <= 1'b0;
      o_rdata  <= 32'h0;
      o_rresp  <= 2'h0;
    end else if (i_arvalid && o_arready) begin
      o_rvalid <= 1'b1;
      o_rdata  <= i_rd_err ? 32'h0 : i_rd_data;
      o_rresp  <= i_rd_err ? 2'h2 : 2'h0;
    end else if (i_rready) begin
      o_rvalid <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// ==== dcl_log.sv ====
// Five-slot diagnostic fault log with selector display and tool access
`timescale 1ns/1ps
`default_nettype none
`include "dcl_map.svh"

module dcl_log
  import dcl_pkg::*;
#(
  parameter int NSLOT  = `DCL_NSLOT,
  parameter int ADDR_W = 8
) (
  input  wire logic              i_core_clk,
  input  wire logic              i_rst_n,
  input  wire logic              i_axi_awvalid,
  output logic                   o_axi_awready,
  input  wire logic [ADDR_W-1:0] i_axi_awaddr,
  input  wire logic              i_axi_wvalid,
  output logic                   o_axi_wready,
  input  wire logic [31:0]       i_axi_wdata,
  input  wire logic [3:0]        i_axi_wstrb,
  output logic                   o_axi_bvalid,
  input  wire logic              i_axi_bready,
  output logic [1:0]             o_axi_bresp,
  input  wire logic              i_axi_arvalid,
  output logic                   o_axi_arready,
  input  wire logic [ADDR_W-1:0] i_axi_araddr,
  output logic                   o_axi_rvalid,
  input  wire logic              i_axi_rready,
  output logic [31:0]            o_axi_rdata,
  output logic [1:0]             o_axi_rresp,
  input  wire logic              i_flt_valid,
  input  wire dcl_code_t         i_flt_code,
  input  wire logic              i_gone_valid,
  input  wire dcl_code_t         i_gone_code,
  input  wire logic              i_pwr_down,
  input  wire logic              i_out_speed_zero,
  input  wire logic              i_oss_fault,
  input  wire logic              i_sel_clr_act,
  input  wire logic              i_sel_clr_inact,
  input  wire logic [2:0]        i_disp_slot,
  output dcl_disp_t              o_disp,
  output logic                   o_mode_lamp,
  output logic                   o_irq
);

  localparam int IDX_W = $clog2(NSLOT);

  // Two BCD digits per code field
  function automatic logic is_bcd(input logic [7:0] v);
    return (v[7:4] <= 4'h9) && (v[3:0] <= 4'h9);
  endfunction

  // Same fault means same main code and same subcode
  function automatic logic same_code(input dcl_entry_t e,
                                     input dcl_code_t  c);
    return e.valid && (e.main_code == c.main_code) &&
           (e.sub_code == c.sub_code);
  endfunction

  // Tool view of an entry: all five fields plus occupancy
  function automatic logic [31:0] pack_entry(input dcl_entry_t e);
    logic [31:0] w;
    w = 32'h0;
    w[`DCL_F_MAIN +: 8]         = e.main_code;
    w[`DCL_F_SUB +: 8]          = e.sub_code;
    w[`DCL_F_ICC +: `DCL_ICC_W] = e.icc;
    w[`DCL_F_ACT]               = e.active;
    w[`DCL_F_VLD]               = e.valid;
    w[`DCL_F_EVT +: `DCL_EVT_W] = e.evt;
    return w;
  endfunction

  dcl_entry_t              log_q [NSLOT];
  dcl_entry_t              log_d [NSLOT];
  logic [`DCL_STS_W-1:0]   sts_q;
  logic [`DCL_STS_W-1:0]   mask_q;
  dcl_disp_t               disp_q;

  logic                    flt_go;
  logic                    hit;
  logic [IDX_W-1:0]        hit_idx;
  logic [`DCL_EVT_W-1:0]   hit_evt;
  logic                    clr_ok;
  logic                    clr_act_req;
  logic                    clr_inact_req;
  logic                    clr_act_go;
  logic                    aged;
  logic [`DCL_STS_W-1:0]   sts_set;

  logic                    wr_en;
  logic [ADDR_W-1:0]       wr_addr;
  logic [31:0]             wr_data;
  logic [3:0]              wr_strb;
  logic                    wr_err;
  logic [ADDR_W-1:0]       rd_addr;
  logic [31:0]             rd_data;
  logic                    rd_err;
  logic [ADDR_W-3:0]       rd_idx;
  logic                    wr_ctrl;
  logic                    wr_sts;
  logic                    wr_mask;

  // Register bus front end
  dcl_axil #(
    .ADDR_W (ADDR_W)
  ) u_axil (
    .i_core_clk (i_core_clk),
    .i_rst_n    (i_rst_n),
    .i_awvalid  (i_axi_awvalid),
    .o_awready  (o_axi_awready),
    .i_awaddr   (i_axi_awaddr),
    .i_wvalid   (i_axi_wvalid),
    .o_wready   (o_axi_wready),
    .i_wdata    (i_axi_wdata),
    .i_wstrb    (i_axi_wstrb),
    .o_bvalid   (o_axi_bvalid),
    .i_bready   (i_axi_bready),
    .o_bresp    (o_axi_bresp),
    .i_arvalid  (i_axi_arvalid),
    .o_arready  (o_axi_arready),
    .i_araddr   (i_axi_araddr),
    .o_rvalid   (o_axi_rvalid),
    .i_rready   (i_axi_rready),
    .o_rdata    (o_axi_rdata),
    .o_rresp    (o_axi_rresp),
    .o_wr_en    (wr_en),
    .o_wr_addr  (wr_addr),
    .o_wr_data  (wr_data),
    .o_wr_strb  (wr_strb),
    .i_wr_err   (wr_err),
    .o_rd_addr  (rd_addr),
    .i_rd_data  (rd_data),
    .i_rd_err   (rd_err)
  );

  // Write decode; control, status and mask all live in byte lane 0
  assign wr_ctrl = wr_en && wr_strb[0] && (wr_addr == `DCL_OFS_CTRL);
  assign wr_sts  = wr_en && wr_strb[0] && (wr_addr == `DCL_OFS_STS);
  assign wr_mask = wr_en && wr_strb[0] && (wr_addr == `DCL_OFS_MASK);
  assign wr_err  = !((wr_addr == `DCL_OFS_CTRL) ||
                     (wr_addr == `DCL_OFS_STS) ||
                     (wr_addr == `DCL_OFS_MASK));

  // Read decode: entry words first, then control, status, mask and the clear-permitted info bit
  assign rd_idx = rd_addr[ADDR_W-1:2];
  always_comb begin
    rd_data = 32'h0;
    rd_err  = 1'b0;
    if (rd_addr[1:0] != 2'h0) begin
      rd_err = 1'b1;
    end else if (rd_idx < ADDR_W'(NSLOT) - 1'b0) begin
      rd_data = pack_entry(log_q[rd_idx[IDX_W-1:0]]);
    end else if (rd_addr == `DCL_OFS_CTRL) begin
      rd_data = 32'h0;
    end else if (rd_addr == `DCL_OFS_STS) begin
      rd_data[`DCL_STS_W-1:0] = sts_q;
    end else if (rd_addr == `DCL_OFS_MASK) begin
      rd_data[`DCL_STS_W-1:0] = mask_q;
    end else if (rd_addr == `DCL_OFS_INFO) begin
      rd_data[0] = clr_ok;
    end else begin
      rd_err = 1'b1;
    end
  end

  // Only well-formed decimal codes are logged
  assign flt_go = i_flt_valid && is_bcd(i_flt_code.main_code) &&
                  is_bcd(i_flt_code.sub_code);

  // Look for a repeat of the reported fault; list order gives priority
  always_comb begin
    hit     = 1'b0;
    hit_idx = '0;
    hit_evt = '0;
    for (int i = NSLOT - 1; i >= 0; i--) begin
      if (same_code(log_q[i], i_flt_code)) begin
        hit     = 1'b1;
        hit_idx = IDX_W'(i);
        hit_evt = log_q[i].evt;
      end
    end
  end

  // Clearing active flags is unsafe while the output shaft turns
  assign clr_ok        = i_out_speed_zero && !i_oss_fault;
  assign clr_act_req   = i_sel_clr_act || (wr_ctrl && wr_data[`DCL_C_CLR_ACT]);
  assign clr_inact_req = i_sel_clr_inact ||
                         (wr_ctrl && wr_data[`DCL_C_CLR_INACT]);
  assign clr_act_go    = clr_act_req && clr_ok;

  // Next list: power-down, then clears, then the new fault, then compaction.
  // The fault goes after the clears so a report in a clearing cycle is never lost.
  always_comb begin
    dcl_entry_t       st [NSLOT];
    dcl_entry_t       nw;
    logic [IDX_W-1:0] p;
    logic             keep;
    int               k;
    st   = log_q;
    nw   = '0;
    p    = '0;
    keep = 1'b0;
    k    = 0;
    aged = 1'b0;
    for (int i = 0; i < NSLOT; i++) begin
      if (i_pwr_down && st[i].valid) begin
        if (st[i].icc != `DCL_ICC_MAX)
          st[i].icc = st[i].icc + 1'b1;
        st[i].active = 1'b0;
      end
      if (clr_act_go || (i_gone_valid && same_code(st[i], i_gone_code)))
        st[i].active = 1'b0;
    end
    if (flt_go) begin
      nw           = hit ? st[hit_idx] : '0;
      nw.valid     = 1'b1;
      nw.active    = 1'b1;
      nw.main_code = i_flt_code.main_code;
      nw.sub_code  = i_flt_code.sub_code;
      nw.icc       = '0;
      if (!hit)
        nw.evt = `DCL_EVT_W'(1);
      else if (nw.evt != `DCL_EVT_MAX)
        nw.evt = nw.evt + 1'b1;
      // Shift down to the old position, or drop the last slot when new
      p = hit ? hit_idx : IDX_W'(NSLOT - 1);
      for (int i = NSLOT - 1; i > 0; i--) begin
        if (IDX_W'(i) <= p)
          st[i] = st[i - 1];
      end
      st[0] = nw;
    end
    for (int i = 0; i < NSLOT; i++)
      log_d[i] = '0;
    for (int i = 0; i < NSLOT; i++) begin
      keep = st[i].valid && (st[i].active ||
             (!clr_inact_req && (st[i].icc <= `DCL_ICC_LIMIT)));
      if (st[i].valid && !keep)
        aged = 1'b1;
      if (keep) begin
        log_d[k] = st[i];
        k        = k + 1;
      end
    end
  end

  // Entry storage
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      for (int i = 0; i < NSLOT; i++)
        log_q[i] <= '0;
    end else begin
      log_q <= log_d;
    end
  end

  // Interrupt sources; a new event beats a write-one clear
  assign sts_set[`DCL_S_NEW]     = flt_go && !hit;
  assign sts_set[`DCL_S_AGED]    = aged;
  assign sts_set[`DCL_S_REFUSED] = clr_act_req && !clr_ok;

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sts_q  <= `DCL_STS_RST;
      mask_q <= `DCL_MASK_RST;
    end else begin
      sts_q <= (sts_q & ~(wr_sts ? wr_data[`DCL_STS_W-1:0] : '0)) | sts_set;
      if (wr_mask)
        mask_q <= wr_data[`DCL_STS_W-1:0];
    end
  end

  assign o_irq = |(sts_q & mask_q);

  // Display view: position, codes and active only, dashes when empty
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      disp_q <= '{pos: 8'h0, main_code: `DCL_DASH, sub_code: `DCL_DASH,
                  active: 1'b0};
    end else begin
      disp_q.pos <= {`DCL_POS_PREFIX, 4'(i_disp_slot) + 4'h1};
      if (i_disp_slot < 3'(NSLOT) && log_q[i_disp_slot].valid) begin
        disp_q.main_code <= log_q[i_disp_slot].main_code;
        disp_q.sub_code  <= log_q[i_disp_slot].sub_code;
        disp_q.active    <= log_q[i_disp_slot].active;
      end else begin
        disp_q.main_code <= `DCL_DASH;
        disp_q.sub_code  <= `DCL_DASH;
        disp_q.active    <= 1'b0;
      end
    end
  end

  assign o_disp      = disp_q;
  assign o_mode_lamp = disp_q.active;

  // Checks on the log behaviour
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);

  a_slot0_new_fault: assert property (
    flt_go |=> log_q[0].valid && log_q[0].active &&
               log_q[0].main_code == $past(i_flt_code.main_code) &&
               log_q[0].sub_code == $past(i_flt_code.sub_code))
    else $error("new fault not placed in first slot");

  a_new_evt_one: assert property (
    flt_go && !hit |=> log_q[0].evt == `DCL_EVT_W'(1))
    else $error("new entry event count not one");

  a_repeat_evt_inc: assert property (
    flt_go && hit && hit_evt != `DCL_EVT_MAX
      |=> log_q[0].evt == $past(hit_evt) + 1'b1 && log_q[0].icc == '0)
    else $error("repeat fault counters wrong");

  a_full_drop_last: assert property (
    flt_go && !hit && log_q[NSLOT-1].valid && !i_pwr_down &&
    !clr_inact_req && log_q[NSLOT-2].icc <= `DCL_ICC_LIMIT
      |=> log_q[NSLOT-1].main_code == $past(log_q[NSLOT-2].main_code))
    else $error("full log did not shift down");

  a_icc_power_down: assert property (
    i_pwr_down && !flt_go && !clr_inact_req && log_q[0].valid &&
    log_q[0].icc < `DCL_ICC_LIMIT
      |=> log_q[0].icc == $past(log_q[0].icc) + 1'b1)
    else $error("cycle count not advanced at power-down");

  a_no_stale_entry: assert property (
    ##1 !(log_q[0].valid && !log_q[0].active &&
          log_q[0].icc > `DCL_ICC_LIMIT))
    else $error("stale inactive entry kept");

  a_no_gap_list: assert property (
    (!log_q[0].valid -> !log_q[1].valid) &&
    (!log_q[1].valid -> !log_q[2].valid) &&
    (!log_q[2].valid -> !log_q[3].valid) &&
    (!log_q[3].valid -> !log_q[4].valid))
    else $error("entry follows empty slot");

  a_clear_refused: assert property (
    clr_act_req && !clr_ok && !flt_go && !i_pwr_down && log_q[0].active
      |=> log_q[0].active && sts_q[`DCL_S_REFUSED])
    else $error("active flag cleared while moving");

  a_lamp_follows: assert property (
    i_disp_slot == 3'h0 && log_q[0].active |=> o_mode_lamp)
    else $error("mode lamp dark for active entry");

  c_repeat_fault:  cover property (flt_go && hit && hit_idx != '0);
  c_full_insert:   cover property (flt_go && !hit && log_q[NSLOT-1].valid);
  c_entry_aged:    cover property (aged && !clr_inact_req);
  c_clear_refused: cover property (clr_act_req && !clr_ok);

endmodule

`default_nettype wire

// ==== dcl_tool.sv ====
// Diagnostic tool model: AXI4-Lite master that reads and writes the log
`timescale 1ns/1ps
`default_nettype none

module dcl_tool (
  input  wire logic        i_core_clk,
  output var logic         o_awvalid,
  input  wire logic        i_awready,
  output var logic [7:0]   o_awaddr,
  output var logic         o_wvalid,
  input  wire logic        i_wready,
  output var logic [31:0]  o_wdata,
  output var logic [3:0]   o_wstrb,
  input  wire logic        i_bvalid,
  output var logic         o_bready,
  input  wire logic [1:0]  i_bresp,
  output var logic         o_arvalid,
  input  wire logic        i_arready,
  output var logic [7:0]   o_araddr,
  input  wire logic        i_rvalid,
  output var logic         o_rready,
  input  wire logic [31:0] i_rdata,
  input  wire logic [1:0]  i_rresp
);
  // Idle bus from time zero
  initial begin
    {o_awvalid, o_wvalid, o_bready, o_arvalid, o_rready} = '0;
    {o_awaddr, o_araddr, o_wdata, o_wstrb} = '0;
  end

  // One write; address and data offered together, released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    bit aw = 0;
    bit w = 0;
    bit awt = 0;
    bit wt = 0;
    @(posedge i_core_clk);
    o_awvalid <= 1'b1;
    o_awaddr  <= a;
    o_wvalid  <= 1'b1;
    o_wdata   <= d;
    o_wstrb   <= 4'hf;
    o_bready  <= 1'b1;
    // Ready is judged on settled values before the edge that takes it
    while (!(aw && w)) begin
      @(negedge i_core_clk);
      awt = !aw && i_awready;
      wt  = !w && i_wready;
      @(posedge i_core_clk);
      if (awt) begin
        aw = 1;
        o_awvalid <= 1'b0;
        o_awaddr  <= ~a;
      end
      if (wt) begin
        w = 1;
        o_wvalid <= 1'b0;
        o_wdata  <= ~d; // Stale data must not look valid
      end
    end
    do @(negedge i_core_clk); while (!i_bvalid);
    r = i_bresp;
    @(posedge i_core_clk);
    o_bready <= 1'b0;
  endtask

  // One read; counters are only reachable this way
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    @(posedge i_core_clk);
    o_arvalid <= 1'b1;
    o_araddr  <= a;
    o_rready  <= 1'b1;
    do @(negedge i_core_clk); while (!i_arready);
    @(posedge i_core_clk);
    o_arvalid <= 1'b0;
    o_araddr  <= ~a;
    do @(negedge i_core_clk); while (!i_rvalid);
    d = i_rdata;
    r = i_rresp;
    @(posedge i_core_clk);
    o_rready <= 1'b0;
  endtask
endmodule

`default_nettype wire

// ==== diagnostic_code_log_tb.sv ====
// Self-checking bench for the fault log
`timescale 1ns/1ps
`default_nettype none
`include "dcl_map.svh"
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin num_errors++; \
  $display("MISMATCH %0t got %h exp %h", $time, (g), (e)); end end

module diagnostic_code_log_tb;
  import dcl_pkg::*;
  logic i_core_clk, i_rst_n, i_axi_awvalid, o_axi_awready, i_axi_wvalid;
  logic o_axi_wready, o_axi_bvalid, i_axi_bready, i_axi_arvalid;
  logic o_axi_arready, o_axi_rvalid, i_axi_rready;
  logic [7:0] i_axi_awaddr, i_axi_araddr;
  logic [31:0] i_axi_wdata, o_axi_rdata, rv;
  logic [3:0] i_axi_wstrb;
  logic [1:0] o_axi_bresp, o_axi_rresp, rr;
  logic i_flt_valid, i_pwr_down, i_out_speed_zero, i_oss_fault;
  logic o_mode_lamp, o_irq;
  logic [2:0] i_disp_slot;
  dcl_code_t i_flt_code;
  dcl_disp_t o_disp;
  dcl_entry_t ex[5];
  int num_errors, checks;
  integer seed;

  dcl_log dcl_log_inst (.i_core_clk, .i_rst_n, .i_axi_awvalid,
    .o_axi_awready, .i_axi_awaddr, .i_axi_wvalid, .o_axi_wready,
    .i_axi_wdata, .i_axi_wstrb, .o_axi_bvalid, .i_axi_bready, .o_axi_bresp,
    .i_axi_arvalid, .o_axi_arready, .i_axi_araddr, .o_axi_rvalid,
    .i_axi_rready, .o_axi_rdata, .o_axi_rresp, .i_flt_valid, .i_flt_code,
    .i_gone_valid(1'b0), .i_gone_code(16'h0000), .i_pwr_down,
    .i_out_speed_zero, .i_oss_fault, .i_sel_clr_act(1'b0),
    .i_sel_clr_inact(1'b0), .i_disp_slot, .o_disp, .o_mode_lamp, .o_irq);

  dcl_tool dcl_tool_inst (.i_core_clk, .o_awvalid(i_axi_awvalid),
    .i_awready(o_axi_awready), .o_awaddr(i_axi_awaddr),
    .o_wvalid(i_axi_wvalid), .i_wready(o_axi_wready),
    .o_wdata(i_axi_wdata), .o_wstrb(i_axi_wstrb), .i_bvalid(o_axi_bvalid),
    .o_bready(i_axi_bready), .i_bresp(o_axi_bresp),
    .o_arvalid(i_axi_arvalid), .i_arready(o_axi_arready),
    .o_araddr(i_axi_araddr), .i_rvalid(o_axi_rvalid),
    .o_rready(i_axi_rready), .i_rdata(o_axi_rdata), .i_rresp(o_axi_rresp));

  // Entry word as the tool should see it
  function automatic logic [31:0] ent_word(dcl_entry_t e);
    return {e.evt, e.valid, e.active, 1'b0, e.icc, e.sub_code, e.main_code};
  endfunction

  // Random code, two decimal digits per field
  function automatic dcl_code_t rnd_code();
    logic [31:0] r = $random(seed);
    return {r[3:0] % 4'd10, r[7:4] % 4'd10, r[11:8] % 4'd10,
            r[15:12] % 4'd10};
  endfunction

  task automatic pulse_flt(input dcl_code_t c);
    @(posedge i_core_clk);
    i_flt_valid <= 1'b1;
    i_flt_code  <= c;
    @(posedge i_core_clk);
    i_flt_valid <= 1'b0;
  endtask

  // Expected log update for a reported fault, then report it
  task automatic log_fault(input dcl_code_t c);
    int k = 5;
    dcl_entry_t e;
    for (int i = 0; i < 5; i++)
      if (ex[i].valid && {ex[i].main_code, ex[i].sub_code} == c) k = i;
    if (k == 5) begin
      e = '0;
      {e.main_code, e.sub_code} = c;
      e.valid = 1'b1;
      e.evt = 8'h01;
      k = 4;
    end else begin
      e = ex[k];
      if (e.evt != 8'hff) e.evt++;
    end
    e.active = 1'b1;
    e.icc = '0;
    for (int i = k; i > 0; i--) ex[i] = ex[i-1];
    ex[0] = e;
    pulse_flt(c);
  endtask

  // Power-down: counts age, actives drop, stale inactive entries leave
  task automatic pwr_down();
    int j = 0;
    for (int i = 0; i < 5; i++) if (ex[i].valid) begin
      if (ex[i].icc != 5'h1f) ex[i].icc++;
      ex[i].active = 1'b0;
    end
    for (int i = 0; i < 5; i++) if (ex[i].valid && ex[i].icc <= 25) begin
      ex[j] = ex[i];
      j++;
    end
    for (int i = j; i < 5; i++) ex[i] = '0;
    @(posedge i_core_clk);
    i_pwr_down <= 1'b1;
    @(posedge i_core_clk);
    i_pwr_down <= 1'b0;
  endtask

  task automatic chk_all();
    for (int i = 0; i < 5; i++) begin
      dcl_tool_inst.rd(8'(4 * i), rv, rr);
      `CHK(rr, 2'h0)
      if (ex[i].valid) `CHK(rv, ent_word(ex[i]))
      else `CHK(rv[23], 1'b0)
    end
  endtask

  // Walk the display over all five slots
  task automatic chk_disp();
    for (int s = 0; s < 5; s++) begin
      @(posedge i_core_clk);
      i_disp_slot <= 3'(s);
      repeat (2) @(posedge i_core_clk);
      #1;
      `CHK(o_disp, {`DCL_POS_PREFIX, 4'(s + 1), ex[s].valid ? {ex[s].main_code, ex[s].sub_code, ex[s].active} : {`DCL_DASH, `DCL_DASH, 1'b0}})
      `CHK(o_mode_lamp, ex[s].valid & ex[s].active)
    end
  endtask

  task automatic report_and_stop();
    if (num_errors == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial begin
    i_core_clk = 1'b0;
    forever #5 i_core_clk = ~i_core_clk;
  end

  // Watchdog: the sequence needs under a thousand cycles
  initial begin
    repeat (30000) @(posedge i_core_clk);
    num_errors++;
    report_and_stop();
  end

  initial begin
    seed = 32'h2b15;
    {num_errors, checks} = '0;
    {i_rst_n, i_flt_valid, i_pwr_down, i_oss_fault} = '0;
    {i_flt_code, i_disp_slot} = '0;
    i_out_speed_zero = 1'b1;
    foreach (ex[i]) ex[i] = '0;
    repeat (3) @(posedge i_core_clk);
    i_rst_n <= 1'b1;
    chk_all();
    dcl_tool_inst.rd(8'h24, rv, rr);
    `CHK(rr, 2'h2)
    dcl_tool_inst.wr(`DCL_OFS_ENTRY0, 32'h1, rr);
    `CHK(rr, 2'h2)
    dcl_tool_inst.wr(`DCL_OFS_MASK, 32'h1, rr);
    // Overfill the log, then repeat an old fault and send a bad code
    repeat (7) begin
      log_fault(rnd_code());
      chk_all();
    end
    log_fault({ex[3].main_code, ex[3].sub_code});
    chk_all();
    pulse_flt(16'h1a2b);
    chk_all();
    chk_disp();
    `CHK(o_irq, 1'b1)
    dcl_tool_inst.wr(`DCL_OFS_STS, 32'h7, rr);
    dcl_tool_inst.wr(`DCL_OFS_MASK, 32'h0, rr);
    log_fault(16'h9999);
    repeat (2) @(posedge i_core_clk);
    `CHK(o_irq, 1'b0)
    // Moving output, then a sensor fault: clearing must be refused
    for (int c = 0; c < 2; c++) begin
      @(posedge i_core_clk);
      i_out_speed_zero <= c[0];
      i_oss_fault <= c[0];
      dcl_tool_inst.wr(`DCL_OFS_CTRL, 32'h1, rr);
      dcl_tool_inst.rd(`DCL_OFS_STS, rv, rr);
      `CHK(rv[`DCL_S_REFUSED], 1'b1)
      dcl_tool_inst.wr(`DCL_OFS_STS, 32'h4, rr);
    end
    chk_all();
    @(posedge i_core_clk);
    i_oss_fault <= 1'b0;
    dcl_tool_inst.rd(`DCL_OFS_INFO, rv, rr);
    `CHK(rv[0], 1'b1)
    dcl_tool_inst.wr(`DCL_OFS_CTRL, 32'h1, rr);
    foreach (ex[i]) ex[i].active = 1'b0;
    chk_all();
    chk_disp();
    // Age to the limit; only a refreshed entry survives the 26th cycle
    repeat (25) begin
      pwr_down();
      chk_all();
    end
    log_fault({ex[2].main_code, ex[2].sub_code});
    pwr_down();
    chk_all();
    chk_disp();
    report_and_stop();
  end
endmodule

`default_nettype wire
